/* rtl/stam_defs.vh */
// Purpose: constants for the servo trip and alarm manager
// Assumes: 10 MHz core clock, APB register access
// Notes: byte offsets are word aligned
`ifndef STAM_DEFS_VH
`define STAM_DEFS_VH

// ==========================================================
// Timing
`define STAM_CLK_HZ 10000000
`define STAM_CLR_HOLD_MS 120
`define STAM_OVL_HOLD_S 10
`define STAM_FLASH_MS 250

// ==========================================================
// Register byte offsets
`define STAM_REG_CTRL 12'h000
`define STAM_REG_STAT 12'h004
`define STAM_REG_HIST_CNT 12'h008
`define STAM_REG_HIST_BASE 12'h010
`define STAM_HIST_DEPTH 4

// ==========================================================
// Alarm codes
`define STAM_CODE_NONE 8'h00
`define STAM_CODE_UV 8'h0B
`define STAM_CODE_OV 8'h0C
`define STAM_CODE_OC 8'h0E
`define STAM_CODE_OL 8'h10
`define STAM_CODE_EE1 8'h24
`define STAM_CODE_EE2 8'h25
`define STAM_CODE_INH 8'h26

// ==========================================================
// Fault input bit positions
`define STAM_F_OC 0
`define STAM_F_OL 1
`define STAM_F_EE1 2
`define STAM_F_EE2 3
`define STAM_F_INH 4

// ==========================================================
// Control and status fields
`define STAM_CTRL_CLR 0
`define STAM_ST_TRIP 0
`define STAM_ST_OLWAIT 1
`define STAM_ST_NOCLR 2
`define STAM_ST_CODE_LSB 8
`define STAM_ST_CODE_MSB 15

`endif

/* rtl/stam_sync3.v */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to mclk_i
// Notes: output changes once stages two and three agree
`include "stam_defs.vh"

module stam_sync3 (
    input wire mclk_i,
    input wire rst_i,
    input wire d_i,
    output wire q_o
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    reg q_ff;

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff <= 1'b0;
        end else begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                q_ff <= s3_ff;
            end
        end
    end

    assign q_o = q_ff;
endmodule

/* rtl/stam_trip_mgr.v */
// Purpose: fault trip latch, alarm clear qualification and alarm history
// Assumes: fault inputs from detectors on other clocks, APB slave access
// Notes: non-clearable faults release only through rst_i (power cycle)
`include "stam_defs.vh"

module stam_trip_mgr #(
    parameter CLR_CYC = (`STAM_CLK_HZ / 1000) * `STAM_CLR_HOLD_MS,
    parameter OLW_CYC = `STAM_CLK_HZ * `STAM_OVL_HOLD_S,
    parameter FLASH_CYC = (`STAM_CLK_HZ / 1000) * `STAM_FLASH_MS
) (
    input wire mclk_i,
    input wire rst_i,
    input wire fault_clear_in_i,
    input wire drive_en_req_i,
    input wire bus_under_i,
    input wire bus_over_i,
    input wire main_power_ok_i,
    input wire [4:0] fault_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg drive_enable_o,
    output reg fault_alarm_out_o,
    output reg status_red_o,
    output reg [7:0] fault_code_display_o,
    output reg fault_display_on_o
);
    // ==========================================================
    // Input synchronisers
    wire [8:0] raw_in = {main_power_ok_i, bus_over_i, bus_under_i, drive_en_req_i,
                         fault_i};
    wire [8:0] syn;
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
            stam_sync3 u_sync (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .d_i(raw_in[gi]),
                .q_o(syn[gi])
            );
        end
    endgenerate
    wire [4:0] flt = syn[4:0];
    wire en_req = syn[5];
    wire uv = syn[6];
    wire ov = syn[7];
    wire pwr_ok = syn[8];

    wire clr_in;
    stam_sync3 u_sync_clr (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(fault_clear_in_i),
        .q_o(clr_in)
    );

    // ==========================================================
    // Fault encoding, overcurrent has priority, then the other codes in ascending order
    reg [7:0] new_code;
    reg new_fault;
    always @* begin
        new_fault = 1'b1;
        if (flt[`STAM_F_OC]) begin
            new_code = `STAM_CODE_OC;
        end else if (uv && en_req) begin
            new_code = `STAM_CODE_UV;
        end else if (ov) begin
            new_code = `STAM_CODE_OV;
        end else if (flt[`STAM_F_OL]) begin
            new_code = `STAM_CODE_OL;
        end else if (flt[`STAM_F_EE1]) begin
            new_code = `STAM_CODE_EE1;
        end else if (flt[`STAM_F_EE2]) begin
            new_code = `STAM_CODE_EE2;
        end else if (flt[`STAM_F_INH]) begin
            new_code = `STAM_CODE_INH;
        end else begin
            new_code = `STAM_CODE_NONE;
            new_fault = 1'b0;
        end
    end

    // ==========================================================
    // Trip state
    reg trip_ff;
    reg [7:0] code_ff;
    reg noclr_ff;
    reg olwait_ff;
    reg [31:0] olw_cnt_ff;
    reg [31:0] clr_cnt_ff;
    reg [31:0] fl_cnt_ff;
    reg blink_ff;
    reg sw_clr_ff;
    reg [1:0] hist_wr_ff;
    reg [7:0] hist_cnt_ff;
    reg [7:0] hist_mem [0:`STAM_HIST_DEPTH-1];

    wire clr_qual = clr_cnt_ff >= (CLR_CYC - 1);
    wire clr_req = (clr_in && clr_qual) || sw_clr_ff;
    wire clr_ok = clr_req && !noclr_ff && !olwait_ff;
    wire do_trip = !trip_ff && new_fault;
    wire hist_skip = (new_code == `STAM_CODE_UV) || (new_code == `STAM_CODE_EE1) ||
                     (new_code == `STAM_CODE_EE2) || (new_code == `STAM_CODE_INH);

    // Timer counts only a steady hold; release restarts it
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            clr_cnt_ff <= 32'h00000000;
        end else if (!clr_in) begin
            clr_cnt_ff <= 32'h00000000;
        end else if (!clr_qual) begin
            clr_cnt_ff <= clr_cnt_ff + 32'h00000001;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            trip_ff <= 1'b0;
            code_ff <= `STAM_CODE_NONE;
            noclr_ff <= 1'b0;
        end else if (do_trip) begin
            trip_ff <= 1'b1;
            code_ff <= new_code;
            noclr_ff <= (new_code == `STAM_CODE_OC);
        end else if (trip_ff && clr_ok) begin
            trip_ff <= 1'b0;
            code_ff <= `STAM_CODE_NONE;
        end
    end

    // Overload hold-off; dropping main power cancels it
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            olwait_ff <= 1'b0;
            olw_cnt_ff <= 32'h00000000;
        end else if (!pwr_ok) begin
            olwait_ff <= 1'b0;
            olw_cnt_ff <= 32'h00000000;
        end else if (do_trip && new_code == `STAM_CODE_OL) begin
            olwait_ff <= 1'b1;
            olw_cnt_ff <= 32'h00000000;
        end else if (olwait_ff) begin
            if (olw_cnt_ff >= OLW_CYC - 1) begin
                olwait_ff <= 1'b0;
            end else begin
                olw_cnt_ff <= olw_cnt_ff + 32'h00000001;
            end
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fl_cnt_ff <= 32'h00000000;
            blink_ff <= 1'b0;
        end else if (!trip_ff) begin
            fl_cnt_ff <= 32'h00000000;
            blink_ff <= 1'b1;
        end else if (fl_cnt_ff >= FLASH_CYC - 1) begin
            fl_cnt_ff <= 32'h00000000;
            blink_ff <= ~blink_ff;
        end else begin
            fl_cnt_ff <= fl_cnt_ff + 32'h00000001;
        end
    end

    // ==========================================================
    // Alarm history, circular
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hist_wr_ff <= 2'b00;
            hist_cnt_ff <= 8'h00;
        end else if (do_trip && !hist_skip) begin
            hist_wr_ff <= hist_wr_ff + 2'b01;
            if (hist_cnt_ff != 8'hFF) begin
                hist_cnt_ff <= hist_cnt_ff + 8'h01;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (do_trip && !hist_skip) begin
            hist_mem[hist_wr_ff] <= new_code;
        end
    end

    // ==========================================================
    // Outputs
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            drive_enable_o <= 1'b0;
            fault_alarm_out_o <= 1'b0;
            status_red_o <= 1'b0;
            fault_code_display_o <= `STAM_CODE_NONE;
            fault_display_on_o <= 1'b0;
        end else begin
            drive_enable_o <= en_req && !trip_ff && !do_trip;
            fault_alarm_out_o <= !trip_ff && !do_trip;
            status_red_o <= trip_ff;
            fault_code_display_o <= code_ff;
            fault_display_on_o <= trip_ff && blink_ff;
        end
    end

    // ==========================================================
    // APB slave, zero wait states
    wire acc = psel && penable;
    // Offset within the history window, same width as paddr
    wire [11:0] hoff = paddr - `STAM_REG_HIST_BASE;
    wire hit_hist = (paddr >= `STAM_REG_HIST_BASE) &&
                    (paddr < `STAM_REG_HIST_BASE + 4 * `STAM_HIST_DEPTH);
    reg [31:0] rd_mux;
    reg rd_err;
    always @* begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            rd_err = 1'b1;
        end else if (paddr == `STAM_REG_CTRL) begin
            rd_mux = 32'h00000000;
        end else if (paddr == `STAM_REG_STAT) begin
            rd_mux[`STAM_ST_TRIP] = trip_ff;
            rd_mux[`STAM_ST_OLWAIT] = olwait_ff;
            rd_mux[`STAM_ST_NOCLR] = noclr_ff;
            rd_mux[`STAM_ST_CODE_MSB:`STAM_ST_CODE_LSB] = code_ff;
        end else if (paddr == `STAM_REG_HIST_CNT) begin
            rd_mux[7:0] = hist_cnt_ff;
        end else if (hit_hist) begin
            rd_mux[7:0] = hist_mem[hoff[3:2]];
        end else begin
            rd_err = 1'b1;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            sw_clr_ff <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= rd_mux;
            pslverr <= psel && !penable && rd_err;
            sw_clr_ff <= acc && pready && pwrite && (paddr == `STAM_REG_CTRL) &&
                         pwdata[`STAM_CTRL_CLR];
        end
    end
endmodule

/* tb/stam_trip_mgr_props.sv */
// Purpose: port checks for the trip manager
// Assumes: one clock, async reset high
// Notes: bound to every stam_trip_mgr
module stam_trip_mgr_props #(parameter CLR_CYC = 20) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic fault_clear_in_i,
    input wire logic bus_over_i,
    input wire logic [4:0] fault_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic drive_enable_o,
    input wire logic fault_alarm_out_o,
    input wire logic status_red_o,
    input wire logic [7:0] fault_code_display_o,
    input wire logic fault_display_on_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (rst_i);
int hold_n;
logic [3:0] sw_q;
// ==========================================
// Clear sources seen lately
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        hold_n <= 0;
        sw_q <= 4'h0;
    end else begin
        hold_n <= fault_clear_in_i ? hold_n + 1 : 0;
        sw_q <= {sw_q[2:0], psel & penable & pready & pwrite & (paddr == 12'h000) & pwdata[0]};
    end
end
a_trip_blocks: assert property (status_red_o |-> !fault_alarm_out_o && !drive_enable_o)
    else $error("alarm or drive active while tripped");
a_idle_dark: assert property (!status_red_o |-> !fault_display_on_o && fault_code_display_o == 8'h00)
    else $error("display lit without trip");
a_code_held: assert property (status_red_o && $past(status_red_o) |-> $stable(fault_code_display_o))
    else $error("code changed during trip");
a_fault_trips: assert property ($rose(|fault_i) |-> ##[1:10] status_red_o)
    else $error("fault did not trip");
a_over_code: assert property ($rose(bus_over_i) |-> ##[1:10] fault_code_display_o == 8'h0C)
    else $error("overvoltage code missing");
a_oc_latched: assert property (status_red_o && fault_code_display_o == 8'h0E |=> status_red_o)
    else $error("non-clearable trip released");
a_clear_qual: assert property ($fell(status_red_o) |-> hold_n >= CLR_CYC || sw_q != 4'h0)
    else $error("trip cleared without qualified clear");
a_code_flash: assert property ((status_red_o && $stable(fault_display_on_o)) [*8] |-> 1'b0)
    else $error("code display not flashing");
a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
endmodule
bind stam_trip_mgr stam_trip_mgr_props #(.CLR_CYC(CLR_CYC)) i_props (.mclk_i(mclk_i),
    .rst_i(rst_i), .fault_clear_in_i(fault_clear_in_i), .bus_over_i(bus_over_i),
    .fault_i(fault_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .drive_enable_o(drive_enable_o),
    .fault_alarm_out_o(fault_alarm_out_o), .status_red_o(status_red_o),
    .fault_code_display_o(fault_code_display_o), .fault_display_on_o(fault_display_on_o));

/* tb/stam_host.sv */
// Purpose: host side clear input driver
// Assumes: hold length in core clock cycles
// Notes: a new go restarts the hold
module stam_host (
    input wire logic mclk_i,
    input wire logic go_i,
    input wire logic [7:0] len_i,
    output logic clr_o
);
timeunit 1ns;
timeprecision 1ns;
logic [7:0] cnt_ff = 8'h00;
always @(posedge mclk_i) begin
    if (go_i)
        cnt_ff <= len_i;
    else if (cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
end
// Steady level for the whole hold, short holds allowed
assign clr_o = cnt_ff != 8'h00;
endmodule

/* tb/servo_trip_alarm_manager_tb_top.sv */
// Purpose: directed test of the trip manager
// Assumes: shortened counts 20, 50, 4
// Notes: rst_i doubles as power cycle
module servo_trip_alarm_manager_tb_top;
timeunit 1ns;
timeprecision 1ns;
logic mclk_i = 0, rst_i = 1, go = 0, en = 0, uv = 0, ov = 0, pok = 1;
logic psel = 0, penable = 0, pwrite = 0, clr, pready, sv, drv, fault_alarm_out, red, lit;
logic [4:0] flt = 5'h00;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic [7:0] len = 8'h00, code;
logic [6:0] stim [5] = '{7'h20, 7'h40, 7'h04, 7'h08, 7'h10};
logic [7:0] exp_code [5] = '{8'h0B, 8'h0C, 8'h24, 8'h25, 8'h26};
int error_cnt = 0, comparisons = 0;
initial forever #50 mclk_i = ~mclk_i;
stam_trip_mgr #(.CLR_CYC(20), .OLW_CYC(50), .FLASH_CYC(4)) i_stam_trip_mgr (.mclk_i(mclk_i),
    .rst_i(rst_i), .fault_clear_in_i(clr), .drive_en_req_i(en), .bus_under_i(uv),
    .bus_over_i(ov), .main_power_ok_i(pok), .fault_i(flt), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(sv), .drive_enable_o(drv), .fault_alarm_out_o(fault_alarm_out), .status_red_o(red),
    .fault_code_display_o(code), .fault_display_on_o(lit));
stam_host i_stam_host (.mclk_i(mclk_i), .go_i(go), .len_i(len), .clr_o(clr));
task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
        error_cnt++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task close_out;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task tick(input int n);
    repeat (n) @(posedge mclk_i);
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1;
    n = 0;
    do begin
        @(posedge mclk_i);
        n++;
    end while (pready !== 1'b1 && n < 16);
    chk(pready, 1);
    if (pready !== 1'b1)
        close_out;
    rd = prdata;
    psel <= 0;
    penable <= 0;
endtask
task wait_red(input logic lvl);
    int n;
    n = 0;
    while (red !== lvl && n < 300) begin
        @(posedge mclk_i);
        n++;
    end
    chk(red, lvl);
    if (red !== lvl)
        close_out;
endtask
task hold_clear(input logic [7:0] n);
    @(posedge mclk_i);
    len <= n;
    go <= 1;
    @(posedge mclk_i);
    go <= 0;
endtask
initial begin
    tick(20000);
    error_cnt++;
    close_out;
end
initial begin
    tick(16);
    rst_i <= 0;
    en <= 1;
    tick(8);
    chk({fault_alarm_out, drv}, 2'b11);
    flt <= 5'h02;
    wait_red(1);
    flt <= 5'h00;
    chk({fault_alarm_out, drv, code}, 10'h010);
    chk(lit, 1);
    apb(0, 12'h004, 0);
    chk(rd, 32'h1003);
    hold_clear(30);
    tick(34);
    chk(red, 1);
    tick(30);
    hold_clear(10);
    tick(16);
    chk(red, 1);
    hold_clear(30);
    wait_red(0);
    $display("overload clear test done");
    flt <= 5'h02;
    wait_red(1);
    flt <= 5'h00;
    pok <= 0;
    tick(6);
    pok <= 1;
    apb(1, 12'h000, 1);
    tick(4);
    chk(red, 0);
    chk(lit, 0);
    apb(0, 12'h100, 0);
    chk(sv, 1);
    $display("power loss test done");
    for (int i = 0; i < 5; i++) begin
        {ov, uv, flt} <= stim[i];
        wait_red(1);
        chk(code, exp_code[i]);
        {ov, uv, flt} <= 7'h00;
        tick(6);
        apb(1, 12'h000, 1);
        wait_red(0);
    end
    apb(0, 12'h008, 0);
    chk(rd, 3);
    apb(0, 12'h018, 0);
    chk(rd, 32'h0C);
    $display("code table test done");
    flt <= 5'h01;
    wait_red(1);
    flt <= 5'h00;
    tick(6);
    hold_clear(30);
    tick(36);
    apb(1, 12'h000, 1);
    tick(4);
    apb(0, 12'h004, 0);
    chk(rd, 32'h0E05);
    rst_i <= 1;
    tick(2);
    rst_i <= 0;
    tick(4);
    chk({red, fault_alarm_out}, 2'b01);
    $display("non-clearable test done");
    close_out;
end
endmodule
